// file: rtl/cgi_pkg.sv
// constants for the clock generator control and interlock block
`default_nettype none
package cgi_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h36;
  localparam logic [7:0] MULT_OFS = 8'h37;
  localparam logic [7:0] TRIM_OFS = 8'h38;
  localparam logic [7:0] DIV_OFS = 8'h39;
  localparam logic [7:0] STAGE_OFS = 8'h3a;
  // control_status bit positions
  localparam int B_MIE = 7;
  localparam int B_MF = 6;
  localparam int B_MON = 5;
  localparam int B_SEL = 4;
  localparam int B_IEN = 3;
  localparam int B_IST = 2;
  localparam int B_EEN = 1;
  localparam int B_EST = 0;
  // field widths
  localparam int MULT_W = 7;
  localparam int DIV_W = 4;
  // reset values, zero-as-one codes and divider limit
  localparam logic [MULT_W-1:0] MULT_RST = 7'h15;
  localparam logic [7:0] TRIM_RST = 8'h80;
  localparam logic [MULT_W-1:0] MULT_ZERO = 7'h00;
  localparam logic [MULT_W-1:0] MULT_ONE = 7'h01;
  localparam logic [DIV_W-1:0] DIV_MAX = 4'h9;
  // external start-up delay in external clock cycles
  localparam int EXT_DELAY = 4096;
  localparam int EXT_CNT_W = 13;
  localparam logic [EXT_CNT_W-1:0] EXT_DELAY_C = EXT_CNT_W'(EXT_DELAY);
  localparam logic [7:0] RD_ZERO = 8'h00;
endpackage
`default_nettype wire

// file: rtl/cgi_clock_ctrl.sv
// control, status and interlock logic of the on-chip clock generator
// Function
// - interrupt when enable and fault both set
// - interrupt enable needs monitor on; else cleared
// - fault flags when monitor sees clock inactive
// - fault cleared by read then zero write
// - monitor on needs both generators on, stable
// - fault holds monitor on; off conditions clear
// - output clock from external if select set
// - select change needs target generator stable
// - select forced by inactive clock or enable
// - internal enable clearing interlocked, else forced on
// - internal stable set on loop lock
// - internal stable cleared on listed events
// - external enable clearing interlocked, else forced
// - external stable after 4096 external cycles
// - external stable cleared on listed events
// - seven-bit multiplier, zero acts as one
// - multiplier, trim writes ignored while monitoring
// - multiplier resets to twenty-one
// - eight-bit trim resets to mid-range
// - loop filter drives divider; codes above nine saturate
// - stage write blocked when internal on; no reset
// - stop without option halts clocks, outputs low
`default_nettype none
module cgi_clock_ctrl (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [cgi_pkg::ADDR_W-1:0] addr_i,
  input wire logic [cgi_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [cgi_pkg::DATA_W-1:0] rdata_o,
  input wire logic internal_clock_i,
  input wire logic external_clock_i,
  input wire logic int_inactive_i,
  input wire logic ext_inactive_i,
  input wire logic int_locked_i,
  input wire logic stop_mode_i,
  input wire logic oscillator_in_stop_i,
  input wire logic [cgi_pkg::DIV_W-1:0] lf_divide_i,
  input wire logic [7:0] lf_stage_i,
  output logic oscillator_output_clock_o,
  output logic internal_gen_run_o,
  output logic external_gen_run_o,
  output logic monitor_run_o,
  output logic monitor_irq_o,
  output logic [cgi_pkg::MULT_W-1:0] multiplier_factor_o,
  output logic [7:0] trim_factor_o,
  output logic [cgi_pkg::DIV_W-1:0] divide_by_two_count_o,
  output logic [7:0] stage_count_o
);
  import cgi_pkg::*;

  logic mie_q, mf_q, mon_q, sel_q, ien_q, ist_q, een_q, est_q;
  logic mf_armed_q;
  logic [MULT_W-1:0] mult_q;
  logic [7:0] trim_q;
  logic [DIV_W-1:0] div_q;
  logic [7:0] stage_q;
  logic [EXT_CNT_W-1:0] ecnt_q;
  logic [1:0] isync_q, esync_q;
  logic ext_last_q;
  logic clk_out_q;

  // register bus decode
  logic wr_ctrl, wr_mult, wr_trim, wr_div, wr_stage, rd_ctrl;
  assign wr_ctrl = wr_i && (addr_i == CTRL_OFS);
  assign wr_mult = wr_i && (addr_i == MULT_OFS) && !mon_q;
  assign wr_trim = wr_i && (addr_i == TRIM_OFS) && !mon_q;
  assign wr_div = wr_i && (addr_i == DIV_OFS) && !ien_q;
  assign wr_stage = wr_i && (addr_i == STAGE_OFS) && !ien_q;
  assign rd_ctrl = rd_i && (addr_i == CTRL_OFS);

  // stop without the keep-running option halts everything
  logic stop_kill;
  assign stop_kill = stop_mode_i && !oscillator_in_stop_i;

  // clock pins come from outside, two flops before use
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      isync_q <= 2'b00;
      esync_q <= 2'b00;
      ext_last_q <= 1'b0;
    end else begin
      isync_q <= {isync_q[0], internal_clock_i};
      esync_q <= {esync_q[0], external_clock_i};
      ext_last_q <= esync_q[1];
    end
  end

  logic ext_rise;
  assign ext_rise = esync_q[1] && !ext_last_q;

  // all permissions below read the _q state of the last cycle
  logic wbit_mie, wbit_mon, wbit_sel, wbit_ien, wbit_een;
  assign wbit_mie = wdata_i[B_MIE];
  assign wbit_mon = wdata_i[B_MON];
  assign wbit_sel = wdata_i[B_SEL];
  assign wbit_ien = wdata_i[B_IEN];
  assign wbit_een = wdata_i[B_EEN];

  // fault flag: set beats the software clear
  logic mf_set;
  assign mf_set = mon_q && (int_inactive_i || ext_inactive_i);
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mf_q <= 1'b0;
      mf_armed_q <= 1'b0;
    end else if (!mon_q) begin
      mf_q <= 1'b0;
      mf_armed_q <= 1'b0;
    end else begin
      if (mf_set) begin
        mf_q <= 1'b1;
      end else if (wr_ctrl && mf_armed_q && !wdata_i[B_MF]) begin
        mf_q <= 1'b0;
      end
      if (rd_ctrl && mf_q) begin
        mf_armed_q <= 1'b1;
      end else if (wr_ctrl) begin
        mf_armed_q <= 1'b0;
      end
    end
  end

  // monitor interrupt enable
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mie_q <= 1'b0;
    end else if (!mon_q) begin
      mie_q <= 1'b0;
    end else if (wr_ctrl) begin
      mie_q <= wbit_mie;
    end
  end

  // monitor on: off conditions outrank the fault hold
  logic mon_ok;
  assign mon_ok = ien_q && een_q && ist_q && est_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mon_q <= 1'b0;
    end else if (!ien_q || !een_q || stop_kill) begin
      mon_q <= 1'b0;
    end else if (mf_q) begin
      mon_q <= 1'b1;
    end else if (wr_ctrl) begin
      if (wbit_mon && mon_ok) begin
        mon_q <= 1'b1;
      end else if (!wbit_mon) begin
        mon_q <= 1'b0;
      end
    end
  end

  // clock select; loss of the external clock wins
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sel_q <= 1'b0;
    end else if ((mon_q && ext_inactive_i) || !een_q) begin
      sel_q <= 1'b0;
    end else if ((mon_q && int_inactive_i) || !ien_q) begin
      sel_q <= 1'b1;
    end else if (wr_ctrl) begin
      if (wbit_sel && een_q && est_q) begin
        sel_q <= 1'b1;
      end else if (!wbit_sel && ien_q && ist_q) begin
        sel_q <= 1'b0;
      end
    end
  end

  // internal generator enable
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ien_q <= 1'b1;
    end else if (mon_q || !sel_q) begin
      ien_q <= 1'b1;
    end else if (wr_ctrl) begin
      ien_q <= wbit_ien;
    end
  end

  // external generator enable
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      een_q <= 1'b0;
    end else if (mon_q || sel_q) begin
      een_q <= 1'b1;
    end else if (wr_ctrl) begin
      een_q <= wbit_een;
    end
  end

  // internal stable follows loop lock unless disturbed
  logic ist_clr;
  assign ist_clr = (mon_q && int_inactive_i) || !ien_q || wr_mult || wr_trim || stop_kill;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ist_q <= 1'b0;
    end else if (ist_clr) begin
      ist_q <= 1'b0;
    end else begin
      ist_q <= int_locked_i;
    end
  end

  // external start-up delay counter, a delay and no real check
  logic est_clr;
  assign est_clr = (mon_q && ext_inactive_i) || !een_q || stop_kill;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ecnt_q <= '0;
      est_q <= 1'b0;
    end else if (est_clr) begin
      ecnt_q <= '0;
      est_q <= 1'b0;
    end else if (ext_rise && !est_q) begin
      ecnt_q <= ecnt_q + EXT_CNT_W'(1);
      est_q <= (ecnt_q + EXT_CNT_W'(1)) == EXT_DELAY_C;
    end
  end

  // multiplier and trim
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mult_q <= MULT_RST;
      trim_q <= TRIM_RST;
    end else begin
      if (wr_mult) begin
        mult_q <= wdata_i[MULT_W-1:0];
      end
      if (wr_trim) begin
        trim_q <= wdata_i;
      end
    end
  end

  // divider and stage have no reset; after reset they follow the loop filter
  always_ff @(posedge clk_sys_i) begin
    if (ien_q) begin
      div_q <= lf_divide_i;
      stage_q <= lf_stage_i;
    end else begin
      if (wr_div) begin
        div_q <= wdata_i[DIV_W-1:0];
      end
      if (wr_stage) begin
        stage_q <= wdata_i;
      end
    end
  end

  // output clock mux, held low when halted
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      clk_out_q <= 1'b0;
    end else if (stop_kill) begin
      clk_out_q <= 1'b0;
    end else begin
      clk_out_q <= sel_q ? esync_q[1] : isync_q[1];
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= RD_ZERO;
    end else if (rd_i) begin
      unique case (addr_i)
        CTRL_OFS: rdata_o <= {mie_q, mf_q, mon_q, sel_q, ien_q, ist_q, een_q, est_q};
        MULT_OFS: rdata_o <= {1'b0, mult_q};
        TRIM_OFS: rdata_o <= trim_q;
        DIV_OFS: rdata_o <= {4'h0, div_q};
        STAGE_OFS: rdata_o <= stage_q;
        default: rdata_o <= RD_ZERO;
      endcase
    end else begin
      rdata_o <= RD_ZERO;
    end
  end

  // outputs toward the analog side
  assign monitor_irq_o = mie_q && mf_q;
  assign oscillator_output_clock_o = clk_out_q;
  assign internal_gen_run_o = ien_q && !stop_kill;
  assign external_gen_run_o = een_q && !stop_kill;
  assign monitor_run_o = mon_q;
  assign multiplier_factor_o = (mult_q == MULT_ZERO) ? MULT_ONE : mult_q;
  assign trim_factor_o = trim_q;
  assign divide_by_two_count_o = (div_q > DIV_MAX) ? DIV_MAX : div_q;
  assign stage_count_o = stage_q;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  irq_gate_a: assert property (monitor_irq_o |-> $past(mon_q))
    else $error("interrupt raised without monitor on");
  mie_guard_a: assert property (!mon_q |=> !mie_q)
    else $error("interrupt enable set without monitor");
  fault_set_a: assert property (mon_q && int_inactive_i && ien_q && een_q && !stop_kill
    |=> mf_q)
    else $error("fault flag missed inactive clock");
  fault_clear_a: assert property ($fell(mf_q) && $past(mon_q) |-> $past(wr_ctrl))
    else $error("fault flag cleared without write");
  mon_entry_a: assert property ($rose(mon_q) |-> $past(mon_ok) && $past(wr_ctrl))
    else $error("monitor on without stable generators");
  mon_hold_a: assert property (mf_q && ien_q && een_q && !stop_kill |=> mon_q)
    else $error("monitor dropped while fault set");
  sel_set_a: assert property ($rose(sel_q) && een_q |-> $past(een_q && est_q) ||
    $past(int_inactive_i) || !$past(ien_q))
    else $error("select set without stable external");
  ien_force_a: assert property (!sel_q |=> ien_q)
    else $error("internal enable off with internal selected");
  een_force_a: assert property (mon_q || sel_q |=> een_q)
    else $error("external enable off while needed");
  ist_clear_a: assert property (wr_mult |=> !ist_q)
    else $error("internal stable held after multiplier write");
  mult_lock_a: assert property (wr_i && addr_i == MULT_OFS && mon_q |=> $stable(mult_q))
    else $error("multiplier written while monitoring");
  stop_low_a: assert property (stop_kill |=> !oscillator_output_clock_o)
    else $error("output clock running in stop");
  // forced clears, interlocks, start-up count, trim lock and loop-filter ownership
  sel_clear_a: assert property ((mon_q && ext_inactive_i) || !een_q |=> !sel_q)
    else $error("select stayed external without external clock");
  est_clear_a: assert property ((mon_q && ext_inactive_i) || !een_q || stop_kill |=> !est_q)
    else $error("external stable held after clear event");
  est_count_a: assert property ($rose(est_q) |-> ecnt_q == EXT_DELAY_C)
    else $error("external stable before full start-up count");
  ien_clear_a: assert property ($fell(ien_q) |-> $past(sel_q) && !$past(mon_q))
    else $error("internal enable cleared while interlocked");
  een_clear_a: assert property ($fell(een_q) |-> !$past(sel_q) && !$past(mon_q))
    else $error("external enable cleared while interlocked");
  mie_set_a: assert property ($rose(mie_q) |-> $past(mon_q))
    else $error("interrupt enable set before monitor on");
  trim_lock_a: assert property (wr_i && addr_i == TRIM_OFS && mon_q |=> $stable(trim_q))
    else $error("trim written while monitoring");
  div_follow_a: assert property (ien_q |=> div_q == $past(lf_divide_i))
    else $error("divider not following loop filter");
  stage_follow_a: assert property (ien_q |=> stage_q == $past(lf_stage_i))
    else $error("stage not following loop filter");
endmodule
`default_nettype wire

// file: dv/clock_generator_control_interlock_bench.sv
// self-checking bench for the clock generator control block
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module clock_generator_control_interlock_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cgi_pkg::*;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, lf_stage_i = 8'h5a;
  logic [7:0] stage_count_o, trim_factor_o;
  logic internal_clock_i = 1'b0, external_clock_i = 1'b0, int_inactive_i = 1'b0;
  logic ext_inactive_i = 1'b0, int_locked_i = 1'b0, stop_mode_i = 1'b0;
  logic oscillator_in_stop_i = 1'b0, ext_run = 1'b0, ext_lvl = 1'b0;
  logic [3:0] lf_divide_i = 4'hc, divide_by_two_count_o;
  logic [6:0] multiplier_factor_o;
  logic oscillator_output_clock_o, internal_gen_run_o, external_gen_run_o;
  logic monitor_run_o, monitor_irq_o;
  logic [7:0] rv;
  logic [1:0] div;
  int error_cnt = 0, checks = 0, cyc = 0, ext_edges = 0;
  cgi_clock_ctrl dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .internal_clock_i(internal_clock_i),
    .external_clock_i(external_clock_i), .int_inactive_i(int_inactive_i),
    .ext_inactive_i(ext_inactive_i), .int_locked_i(int_locked_i), .stop_mode_i(stop_mode_i),
    .oscillator_in_stop_i(oscillator_in_stop_i), .lf_divide_i(lf_divide_i),
    .lf_stage_i(lf_stage_i), .oscillator_output_clock_o(oscillator_output_clock_o),
    .internal_gen_run_o(internal_gen_run_o), .external_gen_run_o(external_gen_run_o),
    .monitor_run_o(monitor_run_o), .monitor_irq_o(monitor_irq_o),
    .multiplier_factor_o(multiplier_factor_o), .trim_factor_o(trim_factor_o),
    .divide_by_two_count_o(divide_by_two_count_o), .stage_count_o(stage_count_o));
  // 250 MHz system clock
  always #2 clk_sys_i = ~clk_sys_i;
  // slow external clock, six system cycles a period so the synchroniser sees every edge
  always @(posedge clk_sys_i) begin
    if (ext_run) begin
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      if (div == 2'h2) external_clock_i <= ~external_clock_i;
      if (div == 2'h2 && !external_clock_i) ext_edges++;
    end else begin
      div <= 2'h0;
      external_clock_i <= ext_lvl;
    end
  end
  // hang guard, well above the 4096-edge start-up wait
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one-cycle write strobe; the leading edge keeps strobes from touching
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // main sequence
  initial begin
    wait_cyc(6);
    rst_i <= 1'b0;
    rd(CTRL_OFS); `CHK(rv, 8'h08)
    @(posedge clk_sys_i); #1 `CHK(rdata_o, RD_ZERO)
    rd(MULT_OFS); `CHK(rv, 8'h15)
    rd(TRIM_OFS); `CHK(rv, TRIM_RST)
    rd(8'h40); `CHK(rv, RD_ZERO)
    wr(MULT_OFS, 8'h00); #1 `CHK(multiplier_factor_o, MULT_ONE)
    wr(MULT_OFS, 8'h15);
    wr(TRIM_OFS, 8'h81); #1 `CHK(trim_factor_o, 8'h81)
    @(posedge clk_sys_i);
    int_locked_i <= 1'b1;
    wait_cyc(3);
    rd(CTRL_OFS); `CHK(rv, 8'h0c)
    // neither monitor nor its interrupt enable may be set yet
    wr(CTRL_OFS, 8'ha8);
    rd(CTRL_OFS); `CHK(rv, 8'h0c)
    wr(CTRL_OFS, 8'h0e);
    ext_run <= 1'b1;
    rd(CTRL_OFS); `CHK(rv, 8'h0e)
    `CHK(external_gen_run_o, 1'b1)
    // one edge short of the start-up count, then the edge that completes it
    wait (ext_edges == EXT_DELAY - 1);
    wait_cyc(4);
    rd(CTRL_OFS); `CHK(rv, 8'h0e)
    wait (ext_edges == EXT_DELAY);
    wait_cyc(4);
    rd(CTRL_OFS); `CHK(rv, 8'h0f)
    wr(CTRL_OFS, 8'h2e);
    rd(CTRL_OFS); `CHK(rv, 8'h2f)
    wr(MULT_OFS, 8'h20); #1 `CHK(multiplier_factor_o, MULT_RST)
    wr(TRIM_OFS, 8'h10); #1 `CHK(trim_factor_o, 8'h81)
    wr(CTRL_OFS, 8'hae);
    rd(CTRL_OFS); `CHK(rv, 8'haf)
    // internal clock loss while monitoring
    @(posedge clk_sys_i); int_inactive_i <= 1'b1;
    @(posedge clk_sys_i); int_inactive_i <= 1'b0;
    wait_cyc(2); #1 `CHK(monitor_irq_o, 1'b1)
    // unarmed clear fails, and monitor cannot drop while the fault stands
    wr(CTRL_OFS, 8'h9e);
    wait_cyc(1); #1 `CHK({monitor_irq_o, monitor_run_o}, 2'b11)
    rd(CTRL_OFS); `CHK(rv[7:4], 4'hf)
    wr(CTRL_OFS, 8'hbe);
    rd(CTRL_OFS); `CHK(rv[7:4], 4'hb)
    #1 `CHK(monitor_irq_o, 1'b0)
    // select is external now: output follows the external level
    @(posedge clk_sys_i);
    ext_run <= 1'b0;
    ext_lvl <= 1'b1;
    wait_cyc(6); #1 `CHK(oscillator_output_clock_o, 1'b1)
    @(posedge clk_sys_i);
    ext_lvl <= 1'b0;
    internal_clock_i <= 1'b1;
    wait_cyc(6); #1 `CHK(oscillator_output_clock_o, 1'b0)
    // with the keep-running option, stop leaves monitor and clock alone
    @(posedge clk_sys_i);
    ext_lvl <= 1'b1;
    oscillator_in_stop_i <= 1'b1;
    stop_mode_i <= 1'b1;
    wait_cyc(6); #1 `CHK({monitor_run_o, oscillator_output_clock_o}, 2'b11)
    @(posedge clk_sys_i);
    oscillator_in_stop_i <= 1'b0;
    wait_cyc(6); #1 `CHK({monitor_run_o, oscillator_output_clock_o}, 2'b00)
    `CHK({internal_gen_run_o, external_gen_run_o}, 2'b00)
    rd(CTRL_OFS); `CHK(rv, 8'h1a)
    `CHK(divide_by_two_count_o, DIV_MAX)
    wr(STAGE_OFS, 8'h33); #1 `CHK(stage_count_o, 8'h5a)
    @(posedge clk_sys_i);
    stop_mode_i <= 1'b0;
    wr(CTRL_OFS, 8'h12);
    rd(CTRL_OFS); `CHK(rv[B_IEN], 1'b0)
    wr(DIV_OFS, 8'h03); #1 `CHK(divide_by_two_count_o, 4'h3)
    wr(STAGE_OFS, 8'h33); #1 `CHK(stage_count_o, 8'h33)
    wr(CTRL_OFS, 8'h02);
    rd(CTRL_OFS); `CHK(rv[B_SEL], 1'b1)
    wr(CTRL_OFS, 8'h10);
    rd(CTRL_OFS); `CHK(rv[B_EEN], 1'b1)
    // second reset in mid-run
    @(posedge clk_sys_i);
    int_locked_i <= 1'b0;
    rst_i <= 1'b1;
    wait_cyc(2);
    rst_i <= 1'b0;
    rd(CTRL_OFS); `CHK(rv, 8'h08)
    rd(MULT_OFS); `CHK(rv, 8'h15)
    finish_test();
  end
endmodule
`undef CHK
`default_nettype wire
